// file: inc/bsx_alu_if.sv
`timescale 1ns/1ps
interface bsx_alu_if;
    import bsx_pkg::*;

    bsx_fgrp_t fGroup;
    bsx_rgrp_t rGroup;
    bsx_word_t regVal;
    bsx_word_t workVal;
    bsx_word_t memVal;
    bsx_word_t inVal;
    bsx_word_t maskVal;
    logic      carryIn;
    bsx_word_t result;
    logic      writeEn;
    logic      toPointer;
    logic      genCarry;
    logic      propCarry;
    logic      carryOut;

    modport core (output fGroup, rGroup, regVal, workVal, memVal, inVal, maskVal, carryIn,
                  input  result, writeEn, toPointer, genCarry, propCarry, carryOut);
    modport alu  (input  fGroup, rGroup, regVal, workVal, memVal, inVal, maskVal, carryIn,
                  output result, writeEn, toPointer, genCarry, propCarry);
    modport look (input  genCarry, propCarry, carryIn,
                  output carryOut);
endinterface : bsx_alu_if

// file: inc/bsx_pkg.sv
package bsx_pkg;

    // ------------------------------------------------------------
    // slice geometry and word constants
    // ------------------------------------------------------------
    localparam int          SLICE_W   = 2;
    localparam int          NUM_GEN   = 10;
    typedef logic [SLICE_W-1:0] bsx_word_t;
    localparam bsx_word_t   ZERO_WORD = 2'h0;
    localparam bsx_word_t   ONES_WORD = 2'h3;

    // ------------------------------------------------------------
    // function bus layout: [6:4] function group, [3:0] register code
    // ------------------------------------------------------------
    localparam int          FB_W      = 7;
    localparam int          FG_LSB    = 4;
    localparam int          FG_MSB    = 6;
    localparam int          RA_MSB    = 3;
    typedef logic [2:0]     bsx_fgrp_t;
    typedef logic [3:0]     bsx_raddr_t;
    localparam bsx_fgrp_t   FG_LOADPTR = 3'h0;
    localparam bsx_fgrp_t   FG_DECR    = 3'h2;
    localparam bsx_fgrp_t   FG_XNOR    = 3'h7;
    localparam bsx_raddr_t  RA_T        = 4'hC;
    localparam bsx_raddr_t  RA_WORK     = 4'hD;
    localparam bsx_raddr_t  RA_II_WORK  = 4'hA;
    localparam bsx_raddr_t  RA_II_T     = 4'hB;
    localparam bsx_raddr_t  RA_III_WORK = 4'hE;

    // register group, one-hot
    typedef enum logic [2:0] {
        RG_ONE   = 3'b001,
        RG_TWO   = 3'b010,
        RG_THREE = 3'b100
    } bsx_rgrp_t;

    // ------------------------------------------------------------
    // slice state
    // ------------------------------------------------------------
    typedef struct packed {
        bsx_word_t [NUM_GEN-1:0] genRegs;
        bsx_word_t               tReg;
        bsx_word_t               work;
        bsx_word_t               mptr;
        logic                    addrOeN;
        logic                    dataOeN;
    } bsx_state_t;

    // register code to register group
    function automatic bsx_rgrp_t decodeRgroup(input bsx_raddr_t ra);
        if (ra == RA_II_WORK || ra == RA_II_T) begin
            return RG_TWO;
        end else if (ra > RA_WORK) begin
            return RG_THREE;
        end
        return RG_ONE;
    endfunction : decodeRgroup

    // groups II and III: even code names the accumulator, odd names T
    function automatic logic selectsWork(input bsx_raddr_t ra);
        return (ra == RA_II_WORK) || (ra == RA_III_WORK);
    endfunction : selectsWork

endpackage : bsx_pkg

// file: rtl/bsx_alu.sv
`timescale 1ns/1ps
module bsx_alu (
    // operands and results
    bsx_alu_if.alu bus
);
    import bsx_pkg::*;

    // ------------------------------------------------------------
    // function decode and datapath
    // ------------------------------------------------------------
    // logic groups report their word-wise OR as generate with propagate
    // held high, so the external look-ahead tree yields carry in OR term
    always_comb begin
        bsx_word_t sum;
        sum           = ZERO_WORD;
        bus.result    = bus.regVal;
        bus.writeEn   = 1'b0;
        bus.toPointer = 1'b0;
        bus.genCarry  = 1'b0;
        bus.propCarry = 1'b1;
        case (bus.fGroup)
            FG_XNOR: begin
                bus.writeEn = 1'b1;
                case (bus.rGroup)
                    RG_ONE: begin
                        bus.result   = ~(bus.regVal ^ (bus.workVal & bus.maskVal));
                        bus.genCarry = |(bus.regVal & bus.workVal & bus.maskVal);
                    end
                    RG_TWO: begin
                        // zero mask gives ~memory, ones mask gives memory xnor work
                        bus.result   = ~(bus.memVal ^ (bus.workVal & bus.maskVal));
                        bus.genCarry = |(bus.memVal & bus.workVal & bus.maskVal);
                    end
                    default: begin
                        bus.result   = ~(bus.regVal ^ (bus.inVal & bus.maskVal));
                        bus.genCarry = |(bus.regVal & bus.inVal & bus.maskVal);
                    end
                endcase
            end
            FG_DECR: begin
                // subtract one by adding the all-ones word plus carry in
                if (bus.rGroup == RG_THREE) begin
                    sum          = bus.regVal + ONES_WORD;
                    bus.result   = sum + {{(SLICE_W-1){1'b0}}, bus.carryIn};
                    bus.writeEn  = 1'b1;
                    bus.genCarry = |bus.regVal;
                end
            end
            FG_LOADPTR: begin
                if (bus.rGroup == RG_TWO) begin
                    bus.result    = bus.memVal;
                    bus.writeEn   = 1'b1;
                    bus.toPointer = 1'b1;
                end
            end
            default: begin
                bus.result = bus.regVal;
            end
        endcase
    end

endmodule : bsx_alu

// file: rtl/bsx_lookahead.sv
`timescale 1ns/1ps
module bsx_lookahead (
    // generate, propagate and ripple carry
    bsx_alu_if.look bus
);
    import bsx_pkg::*;

    // ------------------------------------------------------------
    // ripple carry from the slice's own generate and propagate
    // ------------------------------------------------------------
    // combinational so that chained slices ripple within one microcycle
    assign bus.carryOut = bus.genCarry | (bus.propCarry & bus.carryIn);

endmodule : bsx_lookahead

// file: rtl/bsx_slice.sv
`timescale 1ns/1ps
// Operation
// - group7 II mask: memory xnor work&mask
// - group7 II zero mask: load ~memory, carry passes
// - group7 II ones mask: work xnor memory
// - group7 III mask: AT xnor (I&K)
// - group7 III zero mask: complement AT
// - group7 III ones mask: I xnor AT
// - subtract one by adding all ones
// - 2-bit slice, chainable to any width
// - five 2-bit buses, three in, two out
// - address from pointer, data from accumulator
// - each output bus has own enable
// - generate and propagate carry outputs
module bsx_slice (
    // clock and reset
    input  wire logic               mclk,
    input  wire logic               sys_rst,
    // microfunction from the sequencer
    input  wire logic [bsx_pkg::FB_W-1:0] functionBus,
    // data inputs
    input  wire bsx_pkg::bsx_word_t memoryBus,
    input  wire bsx_pkg::bsx_word_t inputBus,
    input  wire bsx_pkg::bsx_word_t maskBus,
    input  wire logic               carryInput,
    // output enables
    input  wire logic               dataOutEnable,
    input  wire logic               addrOutEnable,
    // three-state output buses
    output bsx_pkg::bsx_word_t      addressOutBus,
    output logic                    addressOutOeN,
    output bsx_pkg::bsx_word_t      accumOutBus,
    output logic                    accumOutOeN,
    // carry chain
    output logic                    carryOut,
    output logic                    genCarry,
    output logic                    propCarry
);
    import bsx_pkg::*;

    // ------------------------------------------------------------
    // state and decode
    // ------------------------------------------------------------
    bsx_state_t st_q;
    bsx_state_t st_d;
    bsx_fgrp_t  fGroup;
    bsx_raddr_t regAddr;
    bsx_rgrp_t  rGroup;
    logic       workSel;
    bsx_word_t  groupOneVal;
    bsx_word_t  atVal;

    bsx_alu_if aluIf ();

    // function bus is on the sequencer's clock, so no synchroniser
    assign fGroup  = functionBus[FG_MSB:FG_LSB];
    assign regAddr = functionBus[RA_MSB:0];
    assign rGroup  = decodeRgroup(regAddr);
    assign workSel = selectsWork(regAddr);

    // group I names any register but the pointer; T and the accumulator sit above the general file
    always_comb begin
        if (regAddr < 4'(NUM_GEN)) begin
            groupOneVal = st_q.genRegs[regAddr];
        end else if (regAddr == RA_T) begin
            groupOneVal = st_q.tReg;
        end else if (regAddr == RA_WORK) begin
            groupOneVal = st_q.work;
        end else begin
            groupOneVal = ZERO_WORD;
        end
    end

    // groups II and III only ever address AC or T
    assign atVal = workSel ? st_q.work : st_q.tReg;

    // ------------------------------------------------------------
    // operand routing into the arithmetic unit
    // ------------------------------------------------------------
    assign aluIf.fGroup  = fGroup;
    assign aluIf.rGroup  = rGroup;
    assign aluIf.regVal  = (rGroup == RG_ONE) ? groupOneVal : atVal;
    assign aluIf.workVal = st_q.work;
    assign aluIf.memVal  = memoryBus;
    assign aluIf.inVal   = inputBus;
    assign aluIf.maskVal = maskBus;
    assign aluIf.carryIn = carryInput;

    bsx_alu u_alu (
        .bus (aluIf.alu)
    );

    bsx_lookahead u_look (
        .bus (aluIf.look)
    );

    // carries follow the inputs with no register in the path
    assign carryOut  = aluIf.carryOut;
    assign genCarry  = aluIf.genCarry;
    assign propCarry = aluIf.propCarry;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // enables are registered so the pads switch clean of decode glitches;
    // the cost is one cycle from enable to drive
    always_comb begin
        st_d         = st_q;
        st_d.addrOeN = ~addrOutEnable;
        st_d.dataOeN = ~dataOutEnable;
        if (aluIf.writeEn) begin
            if (aluIf.toPointer) begin
                st_d.mptr = aluIf.result;
            end else if (rGroup == RG_ONE) begin
                if (regAddr < 4'(NUM_GEN)) begin
                    st_d.genRegs[regAddr] = aluIf.result;
                end else if (regAddr == RA_T) begin
                    st_d.tReg = aluIf.result;
                end else if (regAddr == RA_WORK) begin
                    st_d.work = aluIf.result;
                end
            end else if (workSel) begin
                st_d.work = aluIf.result;
            end else begin
                st_d.tReg = aluIf.result;
            end
        end
    end

    // single state register, updated at the rising edge
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= '{genRegs: '0, tReg: ZERO_WORD, work: ZERO_WORD,
                      mptr: ZERO_WORD, addrOeN: 1'b1, dataOeN: 1'b1};
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // output buses
    // ------------------------------------------------------------
    // each slice drives only its own two bits; wider words are plain
    // concatenation of slices with carries chained
    assign addressOutBus = st_q.mptr;
    assign accumOutBus   = st_q.work;
    assign addressOutOeN = st_q.addrOeN;
    assign accumOutOeN   = st_q.dataOeN;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    logic xnorOp;
    logic toWork;
    assign xnorOp = (fGroup == FG_XNOR);
    assign toWork = (rGroup != RG_ONE) && workSel;

    chk_xnor_mem_gen : assert property (
        xnorOp && rGroup == RG_TWO && toWork |=>
            st_q.work == ~($past(memoryBus) ^ ($past(st_q.work) & $past(maskBus))))
        else $error("xnor with memory wrote wrong value");

    chk_xnor_mem_carry : assert property (
        xnorOp && rGroup == RG_TWO |->
            carryOut == (carryInput | (|(memoryBus & st_q.work & maskBus))))
        else $error("xnor with memory carry wrong");

    chk_load_inv_mem : assert property (
        xnorOp && rGroup == RG_TWO && maskBus == ZERO_WORD && !workSel |->
            carryOut == carryInput ##1 st_q.tReg == ~$past(memoryBus))
        else $error("inverted memory load wrong");

    chk_xnor_mem_ones : assert property (
        xnorOp && rGroup == RG_TWO && maskBus == ONES_WORD && (|(memoryBus & st_q.work)) |->
            carryOut)
        else $error("xnor memory carry not forced");

    chk_xnor_in_gen : assert property (
        xnorOp && rGroup == RG_THREE && !workSel |=>
            st_q.tReg == ~($past(st_q.tReg) ^ ($past(inputBus) & $past(maskBus))))
        else $error("xnor with input wrote wrong value");

    chk_invert_work_twice : assert property (
        (xnorOp && rGroup == RG_THREE && toWork && maskBus == ZERO_WORD) [*2] |=>
            st_q.work == $past(st_q.work, 2))
        else $error("double complement did not restore");

    chk_xnor_in_carry : assert property (
        xnorOp && rGroup == RG_THREE && maskBus == ONES_WORD |->
            carryOut == (carryInput | (|(inputBus & atVal))))
        else $error("xnor with input carry wrong");

    chk_decr_all_ones : assert property (
        fGroup == FG_DECR && rGroup == RG_THREE && toWork && !carryInput |=>
            st_q.work == $past(st_q.work) - 2'h1)
        else $error("decrement wrong");

    chk_pointer_to_bus : assert property (
        fGroup == FG_LOADPTR && rGroup == RG_TWO |=>
            addressOutBus == $past(memoryBus))
        else $error("address bus does not show pointer");

    chk_enable_split : assert property (
        dataOutEnable && !addrOutEnable |=> !accumOutOeN && addressOutOeN)
        else $error("output enables not independent");

    chk_lookahead_sum : assert property (
        carryOut == (genCarry | (propCarry & carryInput)))
        else $error("carry does not match generate and propagate");

    chk_idle_holds : assert property (
        fGroup != FG_XNOR && fGroup != FG_DECR && fGroup != FG_LOADPTR |=>
            $stable(st_q.work) && $stable(st_q.tReg) && $stable(st_q.mptr))
        else $error("register changed on unused function");

    chk_t_dest_only : assert property (
        xnorOp && rGroup == RG_TWO && !workSel |=> $stable(st_q.work))
        else $error("T destination disturbed accumulator");

    // memory xnor aimed at T, mask on the accumulator
    chk_xnor_mem_t : assert property (
        xnorOp && rGroup == RG_TWO && !workSel |=>
            st_q.tReg == ~($past(memoryBus) ^ ($past(st_q.work) & $past(maskBus))))
        else $error("xnor with memory into T wrong");

    // zero mask loads inverted memory into the accumulator
    chk_load_inv_work : assert property (
        xnorOp && rGroup == RG_TWO && maskBus == ZERO_WORD && workSel |=>
            st_q.work == ~$past(memoryBus))
        else $error("inverted load into accumulator wrong");

    // zero mask leaves no generate term
    chk_mem_zero_carry : assert property (
        xnorOp && rGroup == RG_TWO && maskBus == ZERO_WORD |->
            carryOut == carryInput && !genCarry)
        else $error("zero mask memory carry wrong");

    // ones mask: plain xnor of accumulator and memory
    chk_mem_ones_value : assert property (
        xnorOp && rGroup == RG_TWO && maskBus == ONES_WORD && workSel |=>
            st_q.work == ~($past(st_q.work) ^ $past(memoryBus)))
        else $error("ones mask memory xnor wrong");

    // no common bit: carry in is not overridden
    chk_mem_ones_pass : assert property (
        xnorOp && rGroup == RG_TWO && maskBus == ONES_WORD && !(|(memoryBus & st_q.work)) |->
            carryOut == carryInput)
        else $error("ones mask memory carry forced");

    // input xnor into the accumulator, mask on the input bus
    chk_xnor_in_work : assert property (
        xnorOp && rGroup == RG_THREE && workSel |=>
            st_q.work == ~($past(st_q.work) ^ ($past(inputBus) & $past(maskBus))))
        else $error("xnor with input into accumulator wrong");

    // generate term uses the selected register
    chk_xnor_in_term : assert property (
        xnorOp && rGroup == RG_THREE |-> genCarry == (|(atVal & inputBus & maskBus)))
        else $error("xnor with input generate wrong");

    // zero mask complements the accumulator in one cycle
    chk_invert_work_once : assert property (
        xnorOp && rGroup == RG_THREE && toWork && maskBus == ZERO_WORD |=>
            st_q.work == ~$past(st_q.work))
        else $error("complement of accumulator wrong");

    // complement raises no carry of its own
    chk_invert_carry : assert property (
        xnorOp && rGroup == RG_THREE && maskBus == ZERO_WORD |->
            carryOut == carryInput && !genCarry)
        else $error("complement carry wrong");

    // ones mask: plain xnor of input and accumulator
    chk_in_ones_value : assert property (
        xnorOp && rGroup == RG_THREE && toWork && maskBus == ONES_WORD |=>
            st_q.work == ~($past(inputBus) ^ $past(st_q.work)))
        else $error("ones mask input xnor wrong");

    // all ones carries out unless operand and carry in are zero
    chk_decr_carry : assert property (
        fGroup == FG_DECR && rGroup == RG_THREE |->
            carryOut == ((|atVal) | carryInput))
        else $error("decrement carry wrong");

    // all ones plus carry in wraps back to the operand
    chk_decr_carry_in : assert property (
        fGroup == FG_DECR && rGroup == RG_THREE && toWork && carryInput |=>
            $stable(st_q.work))
        else $error("decrement with carry in changed value");

    // address bus moves only on a pointer load
    chk_pointer_hold : assert property (
        fGroup != FG_LOADPTR |=> $stable(addressOutBus))
        else $error("address bus moved without load");

    // address enable acts alone on its own bus
    chk_addr_enable : assert property (
        addrOutEnable && !dataOutEnable |=> !addressOutOeN && accumOutOeN)
        else $error("address enable not independent");

    // functions without a carry term pass carry in
    chk_gen_idle : assert property (
        fGroup != FG_XNOR && fGroup != FG_DECR |-> !genCarry && carryOut == carryInput)
        else $error("generate raised outside carry functions");

    // only register group I reaches the general file
    chk_file_hold : assert property (
        rGroup != RG_ONE |=> $stable(st_q.genRegs))
        else $error("general register changed by wrong group");

    // T destination in group III spares the accumulator
    chk_work_untouched : assert property (
        xnorOp && rGroup == RG_THREE && !workSel |=> $stable(st_q.work))
        else $error("T destination disturbed accumulator");

    // accumulator destination spares T
    chk_t_untouched : assert property (
        rGroup != RG_ONE && workSel |=> $stable(st_q.tReg))
        else $error("accumulator destination disturbed T");

endmodule : bsx_slice

// file: sim/bsx_seq_model.sv
`timescale 1ns/1ps
module bsx_seq_model (
    // clock
    input  wire logic                mclk,
    // microword towards the slice
    output logic [bsx_pkg::FB_W-1:0] functionBus,
    output bsx_pkg::bsx_word_t       memoryBus,
    output bsx_pkg::bsx_word_t       inputBus,
    output bsx_pkg::bsx_word_t       maskBus,
    output logic                     carryInput
);
    import bsx_pkg::*;

    // ------------------------------------------------------------
    // microword source
    // ------------------------------------------------------------
    // idle word selects an undecoded function group, so a stray edge writes nothing
    initial begin
        functionBus = 7'h10;
        memoryBus   = 2'h0;
        inputBus    = 2'h0;
        maskBus     = 2'h0;
        carryInput  = 1'b0;
    end

    // set up off the sampling edge and hold for the whole microcycle
    task automatic issue(input logic [FB_W-1:0] fb, input bsx_word_t m, input bsx_word_t i,
                         input bsx_word_t k, input logic ci);
        @(negedge mclk);
        functionBus = fb;
        memoryBus   = m;
        inputBus    = i;
        maskBus     = k;
        carryInput  = ci;
    endtask : issue
endmodule : bsx_seq_model

// file: sim/bsx_slice_tb_top.sv
`timescale 1ns/1ps
module bsx_slice_tb_top;
    import bsx_pkg::*;

    // ------------------------------------------------------------
    // clock, reset and wiring
    // ------------------------------------------------------------
    logic            mclk;
    logic            sysRst;
    logic            dataOutEnable;
    logic            addrOutEnable;
    logic [FB_W-1:0] functionBus;
    bsx_word_t       memoryBus;
    bsx_word_t       inputBus;
    bsx_word_t       maskBus;
    logic            carryInput;
    bsx_word_t       addressOutBus;
    logic            addressOutOeN;
    bsx_word_t       accumOutBus;
    logic            accumOutOeN;
    logic            carryOut;
    logic            genCarry;
    logic            propCarry;
    int              n_fail;
    int              checks;
    int              cycles;

    bsx_seq_model seq (.mclk(mclk), .functionBus(functionBus), .memoryBus(memoryBus),
                       .inputBus(inputBus), .maskBus(maskBus), .carryInput(carryInput));

    bsx_slice dut (.mclk(mclk), .sys_rst(sysRst), .functionBus(functionBus),
                   .memoryBus(memoryBus), .inputBus(inputBus), .maskBus(maskBus),
                   .carryInput(carryInput), .dataOutEnable(dataOutEnable),
                   .addrOutEnable(addrOutEnable), .addressOutBus(addressOutBus),
                   .addressOutOeN(addressOutOeN), .accumOutBus(accumOutBus),
                   .accumOutOeN(accumOutOeN), .carryOut(carryOut), .genCarry(genCarry),
                   .propCarry(propCarry));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // the whole run needs a few hundred cycles; the ceiling leaves ample margin
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            final_report();
        end
    end

    // ------------------------------------------------------------
    // shared helpers
    // ------------------------------------------------------------
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report

    task automatic chk(input bsx_word_t got, input bsx_word_t exp, input string msg);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
        end
    endtask : chk

    // combinational outputs are judged 5 ns after the microword settles
    task automatic step(input logic [FB_W-1:0] fb, input bsx_word_t m, input bsx_word_t i,
                        input bsx_word_t k, input logic ci);
        seq.issue(fb, m, i, k, ci);
        #5;
    endtask : step

    task automatic tick();
        @(posedge mclk);
        #1;
    endtask : tick

    // accumulator preset by loading the complement of memory
    task automatic setAc(input bsx_word_t a);
        step(7'h7A, ~a, 2'h0, 2'h0, 1'b0);
        tick();
    endtask : setAc

    task automatic xnorCheck(input bsx_word_t a, input bsx_word_t x, input bsx_word_t k,
                             input logic ci, input logic onMem);
        logic      g;
        bsx_word_t r;
        g = |(a & x & k);
        // memory form masks the accumulator, input form masks the input bus
        r = onMem ? ~(x ^ (a & k)) : ~(a ^ (x & k));
        chk({1'b0, genCarry}, {1'b0, g}, "gen");
        chk({1'b0, propCarry}, 2'h1, "prop");
        chk({1'b0, carryOut}, {1'b0, g | ci}, "carry");
        chk(accumOutBus, a, "early write");
        tick();
        chk(accumOutBus, r, "xnor result");
    endtask : xnorCheck

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic test_reset();
        chk(accumOutBus, 2'h0, "reset acc");
        chk({accumOutOeN, addressOutOeN}, 2'h3, "reset enables");
        $display("done reset");
    endtask : test_reset

    // every accumulator, memory and mask value, mask 00 and 11 included
    task automatic test_xnor_mem();
        bsx_word_t a;
        bsx_word_t m;
        bsx_word_t k;
        for (int n = 0; n < 64; n++) begin
            {a, m, k} = 6'(n);
            setAc(a);
            step(7'h7A, m, ~m, k, ^n[2:0]);
            xnorCheck(a, m, k, ^n[2:0], 1'b1);
        end
        $display("done xnor memory");
    endtask : test_xnor_mem

    task automatic test_xnor_in();
        bsx_word_t a;
        bsx_word_t i;
        bsx_word_t k;
        for (int n = 0; n < 64; n++) begin
            {a, i, k} = 6'(n);
            setAc(a);
            step(7'h7E, ~i, i, k, ^n[3:1]);
            xnorCheck(a, i, k, ^n[3:1], 1'b0);
        end
        // two complements back to back restore the accumulator
        setAc(2'h1);
        step(7'h7E, 2'h0, 2'h0, 2'h0, 1'b0);
        tick();
        chk(accumOutBus, 2'h2, "complement");
        step(7'h7E, 2'h0, 2'h0, 2'h0, 1'b0);
        tick();
        chk(accumOutBus, 2'h1, "double complement");
        $display("done xnor input");
    endtask : test_xnor_in

    // adding all ones with no carry in is a decrement
    task automatic test_decrement();
        bsx_word_t a;
        for (int n = 0; n < 8; n++) begin
            a = bsx_word_t'(n >> 1);
            setAc(a);
            step(7'h2E, 2'h0, 2'h0, 2'h0, n[0]);
            chk({1'b0, carryOut}, {1'b0, (|a) | n[0]}, "dec carry");
            tick();
            chk(accumOutBus, a + ONES_WORD + bsx_word_t'(n[0]), "dec");
        end
        $display("done decrement");
    endtask : test_decrement

    task automatic test_buses();
        for (int n = 0; n < 4; n++) begin
            step(7'h0A, bsx_word_t'(n), 2'h0, 2'h0, 1'b0);
            tick();
            chk(addressOutBus, bsx_word_t'(n), "pointer");
            @(negedge mclk);
            // bit 1 feeds the data enable so the low-active pair reads ~n
            dataOutEnable = n[1];
            addrOutEnable = n[0];
            tick();
            chk({accumOutOeN, addressOutOeN}, ~2'(n), "enables");
        end
        $display("done buses");
    endtask : test_buses

    // a write to T leaves the accumulator alone and is seen through the carry
    task automatic test_select();
        setAc(2'h2);
        step(7'h7B, 2'h0, 2'h0, 2'h0, 1'b0);
        tick();
        chk(accumOutBus, 2'h2, "acc after T write");
        step(7'h7F, 2'h0, 2'h3, 2'h3, 1'b0);
        chk({1'b0, carryOut}, 2'h1, "T nonzero");
        tick();
        step(7'h7B, 2'h3, 2'h0, 2'h0, 1'b0);
        tick();
        step(7'h7F, 2'h0, 2'h3, 2'h3, 1'b0);
        chk({1'b0, carryOut}, 2'h0, "T zero");
        tick();
        chk(accumOutBus, 2'h2, "acc kept");
        $display("done select");
    endtask : test_select

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        n_fail        = 0;
        checks        = 0;
        sysRst        = 1'b1;
        dataOutEnable = 1'b0;
        addrOutEnable = 1'b0;
        repeat (12) @(negedge mclk);
        sysRst = 1'b0;
        #1;
        test_reset();
        test_xnor_mem();
        test_xnor_in();
        test_decrement();
        test_buses();
        test_select();
        final_report();
    end
endmodule : bsx_slice_tb_top
